// ===== common/tms_defines.vh
// Register offsets, field positions, reset values and sizes of the trigger monitor.
`ifndef TMS_DEFINES_VH
`define TMS_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define TMS_OFF_CTRL       8'h00
`define TMS_OFF_RATE       8'h04
`define TMS_OFF_SCALE      8'h08
`define TMS_OFF_SWTRIG     8'h0c
`define TMS_OFF_CLEAR      8'h10
`define TMS_OFF_STATUS     8'h14
`define TMS_OFF_MEASURED   8'h18
`define TMS_OFF_HIGHEST    8'h1c
`define TMS_OFF_LOWEST     8'h20
`define TMS_OFF_IN_TALLY   8'h24
`define TMS_OFF_OUT_TALLY  8'h28
`define TMS_OFF_LOST_TALLY 8'h2c
`define TMS_OFF_PFG0       8'h30
`define TMS_OFF_PFG3       8'h3c

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define TMS_CTRL_MODE_LSB  0
`define TMS_CTRL_STATE_LSB 2
`define TMS_CTRL_QUEUE_BIT 4
`define TMS_CTRL_LINE_LSB  5
`define TMS_CTRL_OSEL_LSB  8

// ----------------------------------------------------------------------------
// Clear register bits
// ----------------------------------------------------------------------------
`define TMS_CLR_EXTREMES  0
`define TMS_CLR_IN_TALLY  1
`define TMS_CLR_OUT_TALLY 2
`define TMS_CLR_FLAG      3
`define TMS_CLR_LOST      4

// ----------------------------------------------------------------------------
// Trigger source modes and run states
// ----------------------------------------------------------------------------
`define TMS_MODE_GENERATOR 2'h0
`define TMS_MODE_EXTERNAL  2'h1
`define TMS_MODE_SOFTWARE  2'h2
`define TMS_MODE_SYNC      2'h3
`define TMS_RUN_ACTIVE     2'h0
`define TMS_RUN_DRAIN      2'h1
`define TMS_RUN_ABORT      2'h2

// ----------------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------------
`define TMS_RATE_RST       32'h0001_312d
`define TMS_PFG_WIDTH_RST  16'h0010
`define TMS_QUEUE_DEPTH    11'h7f8

`endif

// ===== rtl/tms_trigger_monitor.v
// Trigger source selection, run state control and monitoring for one camera process.
`timescale 1ns/1ps
`include "tms_defines.vh"

module tms_trigger_monitor (
  // Clock and reset.
  input wire core_clk_i,
  input wire nrst_i,
  // APB slave.
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire pready_o,
  output reg [31:0] prdata_o,
  output reg pslverr_o,
  // Trigger sources and camera feedback.
  input wire [3:0] trig_line_i,
  input wire prev_trig_i,
  input wire first_process_i,
  input wire frame_done_i,
  // Camera trigger outputs and events.
  output reg [3:0] trig_out_o,
  output reg input_pulse_event_o,
  output reg output_pulse_event_o,
  output reg trigger_lost_event_o,
  output reg frame_lost_event_o
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // A factor of zero behaves as one so that software cannot stall the chain.
  function [15:0] at_least_one;
    input [15:0] v;
    begin
      at_least_one = (v == 16'h0000) ? 16'h0001 : v;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Registers and state
  // --------------------------------------------------------------------------
  reg [1:0] trigger_source_mode;
  reg [1:0] trigger_run_state;
  reg pulse_queue_enable;
  reg [1:0] input_line_select;
  reg [1:0] output_tally_select;
  reg [31:0] max_pulse_rate;
  reg [15:0] input_divide_factor;
  reg [15:0] pulse_multiplier;
  reg [15:0] pfg_width [0:3];
  reg [15:0] pfg_cnt [0:3];
  reg [31:0] input_freq_measured;
  reg [31:0] input_freq_highest;
  reg [31:0] input_freq_lowest;
  reg [31:0] period_cnt;
  reg [31:0] input_pulse_tally;
  reg [31:0] output_pulse_tally;
  reg [31:0] lost_frame_tally;
  reg period_limit_exceeded_flag;
  reg frame_outstanding;
  reg [3:0] line_q;
  reg prev_q;
  reg [31:0] gen_cnt;
  reg [15:0] div_cnt;
  reg [10:0] pending;
  reg [15:0] seq_left;
  reg [31:0] gap_cnt;
  reg [31:0] next_rdata;
  reg next_err;
  reg src_pulse;
  integer i;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  wire setup = psel_i & ~penable_i;
  wire wr = psel_i & penable_i & pwrite_i;
  wire wr_ctrl = wr & (paddr_i == `TMS_OFF_CTRL);
  wire wr_clear = wr & (paddr_i == `TMS_OFF_CLEAR);
  wire sw_write = wr & (paddr_i == `TMS_OFF_SWTRIG);
  wire clr_ext = wr_clear & pwdata_i[`TMS_CLR_EXTREMES];
  wire clr_in = wr_clear & pwdata_i[`TMS_CLR_IN_TALLY];
  wire clr_out = wr_clear & pwdata_i[`TMS_CLR_OUT_TALLY];
  wire clr_flag = wr_clear & pwdata_i[`TMS_CLR_FLAG];
  wire clr_lost = wr_clear & pwdata_i[`TMS_CLR_LOST];
  wire [1:0] wr_state = pwdata_i[`TMS_CTRL_STATE_LSB +: 2];
  wire restart = wr_ctrl & (wr_state == `TMS_RUN_ACTIVE) & (trigger_run_state != `TMS_RUN_ACTIVE);

  // No wait states: read data is captured in the setup cycle and stands in the access cycle.
  assign pready_o = psel_i & penable_i;

  always @* begin
    next_err = 1'b0;
    next_rdata = 32'h0000_0000;
    case (paddr_i)
      `TMS_OFF_CTRL: begin
        next_rdata[`TMS_CTRL_MODE_LSB +: 2] = trigger_source_mode;
        next_rdata[`TMS_CTRL_STATE_LSB +: 2] = trigger_run_state;
        next_rdata[`TMS_CTRL_QUEUE_BIT] = pulse_queue_enable;
        next_rdata[`TMS_CTRL_LINE_LSB +: 2] = input_line_select;
        next_rdata[`TMS_CTRL_OSEL_LSB +: 2] = output_tally_select;
      end
      `TMS_OFF_RATE: next_rdata = max_pulse_rate;
      `TMS_OFF_SCALE: next_rdata = {pulse_multiplier, input_divide_factor};
      `TMS_OFF_SWTRIG: next_rdata = 32'h0000_0000;
      `TMS_OFF_CLEAR: next_rdata = 32'h0000_0000;
      `TMS_OFF_STATUS: next_rdata = {5'h00, pending, 14'h0000, frame_outstanding, period_limit_exceeded_flag};
      `TMS_OFF_MEASURED: next_rdata = input_freq_measured;
      `TMS_OFF_HIGHEST: next_rdata = input_freq_highest;
      `TMS_OFF_LOWEST: next_rdata = input_freq_lowest;
      `TMS_OFF_IN_TALLY: next_rdata = input_pulse_tally;
      `TMS_OFF_OUT_TALLY: next_rdata = output_pulse_tally;
      `TMS_OFF_LOST_TALLY: next_rdata = lost_frame_tally;
      default: begin
        if (paddr_i >= `TMS_OFF_PFG0 && paddr_i <= `TMS_OFF_PFG3 && paddr_i[1:0] == 2'h0) begin
          next_rdata = {16'h0000, pfg_width[paddr_i[3:2]]};
        end else begin
          next_err = 1'b1;
        end
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Trigger source selection
  // --------------------------------------------------------------------------
  wire [3:0] line_rise = trig_line_i & ~line_q;
  wire sel_rise = line_rise[input_line_select];
  wire prev_rise = prev_trig_i & ~prev_q;
  wire running = (trigger_run_state == `TMS_RUN_ACTIVE);
  wire halted = (trigger_run_state == `TMS_RUN_ABORT);
  wire [31:0] period_m1 = (max_pulse_rate == 32'h0000_0000) ? 32'h0000_0000 : max_pulse_rate - 32'h0000_0001;
  wire gen_tick = running & (trigger_source_mode == `TMS_MODE_GENERATOR) & (gen_cnt >= period_m1);

  always @* begin
    case (trigger_source_mode)
      `TMS_MODE_GENERATOR: src_pulse = gen_tick;
      `TMS_MODE_EXTERNAL: src_pulse = sel_rise;
      `TMS_MODE_SOFTWARE: src_pulse = sw_write;
      `TMS_MODE_SYNC: src_pulse = prev_rise & ~first_process_i;
      default: src_pulse = 1'b0;
    endcase
  end

  // Only the active state lets a source pulse into the chain.
  wire accept_src = src_pulse & running;
  wire ds_hit = accept_src & (div_cnt >= at_least_one(input_divide_factor) - 16'h0001);
  wire gap_ok = (gap_cnt == 32'h0000_0000);
  // A taken pulse needs two cycles to reach the sequencer, so it may be taken while two gap cycles remain.
  // Waiting for a zero gap would instead drop every second generator tick at the configured rate.
  wire idle = (pending == 11'h000) & (seq_left == 16'h0000) & (gap_cnt <= 32'h0000_0002);
  // Without the queue a pulse is taken only when the chain is idle and at most two gap cycles remain.
  wire can_take = pulse_queue_enable ? (pending < `TMS_QUEUE_DEPTH) : idle;
  wire take = ds_hit & can_take;
  wire discard = ds_hit & ~can_take;
  wire seq_load = ~halted & (seq_left == 16'h0000) & (pending != 11'h000);
  wire fire = ~halted & (seq_left != 16'h0000) & gap_ok;

  // --------------------------------------------------------------------------
  // Main sequential logic
  // --------------------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      trigger_source_mode <= `TMS_MODE_GENERATOR;
      trigger_run_state <= `TMS_RUN_DRAIN;
      pulse_queue_enable <= 1'b0;
      input_line_select <= 2'h0;
      output_tally_select <= 2'h0;
      max_pulse_rate <= `TMS_RATE_RST;
      input_divide_factor <= 16'h0001;
      pulse_multiplier <= 16'h0001;
      for (i = 0; i < 4; i = i + 1) begin
        pfg_width[i] <= `TMS_PFG_WIDTH_RST;
        pfg_cnt[i] <= 16'h0000;
      end
      input_freq_measured <= 32'h0000_0000;
      input_freq_highest <= 32'h0000_0000;
      input_freq_lowest <= 32'h0000_0000;
      period_cnt <= 32'h0000_0000;
      input_pulse_tally <= 32'h0000_0000;
      output_pulse_tally <= 32'h0000_0000;
      lost_frame_tally <= 32'h0000_0000;
      period_limit_exceeded_flag <= 1'b0;
      frame_outstanding <= 1'b0;
      line_q <= 4'h0;
      prev_q <= 1'b0;
      gen_cnt <= 32'h0000_0000;
      div_cnt <= 16'h0000;
      pending <= 11'h000;
      seq_left <= 16'h0000;
      gap_cnt <= 32'h0000_0000;
      trig_out_o <= 4'h0;
      input_pulse_event_o <= 1'b0;
      output_pulse_event_o <= 1'b0;
      trigger_lost_event_o <= 1'b0;
      frame_lost_event_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      line_q <= trig_line_i;
      prev_q <= prev_trig_i;
      if (setup) begin
        prdata_o <= next_rdata;
        pslverr_o <= next_err;
      end

      // Software writes; an unmapped address is answered with pslverr and no effect.
      if (wr_ctrl) begin
        trigger_source_mode <= pwdata_i[`TMS_CTRL_MODE_LSB +: 2];
        if (wr_state != 2'h3) begin
          trigger_run_state <= wr_state;
        end
        pulse_queue_enable <= pwdata_i[`TMS_CTRL_QUEUE_BIT];
        input_line_select <= pwdata_i[`TMS_CTRL_LINE_LSB +: 2];
        output_tally_select <= pwdata_i[`TMS_CTRL_OSEL_LSB +: 2];
      end
      if (wr && paddr_i == `TMS_OFF_RATE) begin
        max_pulse_rate <= pwdata_i;
      end
      if (wr && paddr_i == `TMS_OFF_SCALE) begin
        input_divide_factor <= pwdata_i[15:0];
        pulse_multiplier <= pwdata_i[31:16];
      end
      for (i = 0; i < 4; i = i + 1) begin
        if (wr && paddr_i == (`TMS_OFF_PFG0 + 8'h04 * i[7:0])) begin
          pfg_width[i] <= pwdata_i[15:0];
        end
      end

      // Rate measurement on the selected line runs in every mode and state.
      if (period_cnt != 32'hffff_ffff) begin
        period_cnt <= period_cnt + 32'h0000_0001;
      end
      if (sel_rise) begin
        period_cnt <= 32'h0000_0000;
        input_freq_measured <= period_cnt + 32'h0000_0001;
        if (period_cnt + 32'h0000_0001 < input_freq_highest) begin
          input_freq_highest <= period_cnt + 32'h0000_0001;
        end
        if (period_cnt + 32'h0000_0001 > input_freq_lowest) begin
          input_freq_lowest <= period_cnt + 32'h0000_0001;
        end
      end
      if (clr_ext) begin
        input_freq_highest <= 32'hffff_ffff;
        input_freq_lowest <= 32'h0000_0000;
      end

      // Input side: events, tally and downscale.
      input_pulse_event_o <= accept_src;
      if (clr_in) begin
        input_pulse_tally <= 32'h0000_0000;
      end else if (accept_src) begin
        input_pulse_tally <= input_pulse_tally + 32'h0000_0001;
      end
      if (accept_src) begin
        div_cnt <= ds_hit ? 16'h0000 : div_cnt + 16'h0001;
      end
      if (running && trigger_source_mode == `TMS_MODE_GENERATOR) begin
        gen_cnt <= gen_tick ? 32'h0000_0000 : gen_cnt + 32'h0000_0001;
      end else begin
        gen_cnt <= 32'h0000_0000;
      end
      trigger_lost_event_o <= discard;
      if (discard) begin
        period_limit_exceeded_flag <= 1'b1;
      end else if (clr_flag) begin
        period_limit_exceeded_flag <= 1'b0;
      end

      // Queue and sequencer keep running in the drain state and freeze when aborted.
      pending <= pending + {10'h000, take} - {10'h000, seq_load};
      if (seq_load) begin
        seq_left <= at_least_one(pulse_multiplier);
      end else if (fire) begin
        seq_left <= seq_left - 16'h0001;
      end
      if (fire) begin
        gap_cnt <= period_m1;
      end else if (!gap_ok && !halted) begin
        gap_cnt <= gap_cnt - 32'h0000_0001;
      end

      // Pulse form generators; an abort truncates any pulse in progress.
      for (i = 0; i < 4; i = i + 1) begin
        if (halted) begin
          pfg_cnt[i] <= 16'h0000;
          trig_out_o[i] <= 1'b0;
        end else if (fire) begin
          pfg_cnt[i] <= pfg_width[i];
          trig_out_o[i] <= (pfg_width[i] != 16'h0000);
        end else begin
          pfg_cnt[i] <= (pfg_cnt[i] != 16'h0000) ? pfg_cnt[i] - 16'h0001 : 16'h0000;
          trig_out_o[i] <= (pfg_cnt[i] > 16'h0001);
        end
      end
      output_pulse_event_o <= fire;
      if (clr_out) begin
        output_pulse_tally <= 32'h0000_0000;
      end else if (fire && pfg_width[output_tally_select] != 16'h0000) begin
        output_pulse_tally <= output_pulse_tally + 32'h0000_0001;
      end

      // A trigger sent while the previous frame is still missing counts as a lost frame.
      frame_lost_event_o <= fire & frame_outstanding & ~frame_done_i;
      frame_outstanding <= fire | (frame_outstanding & ~frame_done_i);
      if (clr_lost) begin
        lost_frame_tally <= 32'h0000_0000;
      end else if (fire && frame_outstanding && !frame_done_i) begin
        lost_frame_tally <= lost_frame_tally + 32'h0000_0001;
      end

      // Returning to the active state from drain or abort flushes the queue and sequencer; placed last so it wins.
      if (restart) begin
        pending <= 11'h000;
        seq_left <= 16'h0000;
        gap_cnt <= 32'h0000_0000;
        div_cnt <= 16'h0000;
      end
    end
  end

endmodule

// ===== test/tms_checker.sv
// Port-level assertions for the trigger monitor.
`timescale 1ns/1ps
module tms_checker (
  // Clock, reset and APB.
  input wire core_clk_i,
  input wire nrst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  // Trigger side.
  input wire [3:0] trig_line_i,
  input wire prev_trig_i,
  input wire first_process_i,
  input wire [3:0] trig_out_o,
  input wire input_pulse_event_o,
  input wire output_pulse_event_o,
  input wire trigger_lost_event_o
);
  // --------------------------------------------------------------------------
  // Shadow of the control word
  // --------------------------------------------------------------------------
  reg [1:0] mode;
  reg [1:0] st;
  reg [1:0] sel;
  reg [3:0] stay;
  reg [3:0] sw_age;
  wire acc = psel_i && penable_i && pwrite_i;
  wire ctrl_wr = acc && paddr_i == 8'h00;
  wire sw_wr = acc && paddr_i == 8'h0c;
  // Checks wait a few cycles after a control write, since work in flight may still finish.
  wire calm = stay > 4'h4;
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      mode <= 2'h0;
      st <= 2'h1;
      sel <= 2'h0;
      stay <= 4'h0;
      sw_age <= 4'hf;
    end else begin
      if (ctrl_wr) begin
        mode <= pwdata_i[1:0];
        sel <= pwdata_i[6:5];
      end
      if (ctrl_wr && pwdata_i[3:2] != 2'h3) begin
        st <= pwdata_i[3:2];
      end
      stay <= ctrl_wr ? 4'h0 : (stay == 4'hf ? stay : stay + 4'h1);
      sw_age <= sw_wr ? 4'h0 : (sw_age == 4'hf ? sw_age : sw_age + 4'h1);
    end
  end
  default clocking dc @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  drain_quiet_a: assert property (st == 2'h1 && calm |-> !input_pulse_event_o)
    else $error("input event while drained");
  abort_quiet_a: assert property (st == 2'h2 && calm |-> trig_out_o == 4'h0 && !output_pulse_event_o)
    else $error("output while aborted");
  abort_cut_a: assert property (ctrl_wr && pwdata_i[3:2] == 2'h2 |-> ##2 trig_out_o == 4'h0)
    else $error("abort did not cut outputs");
  sw_only_a: assert property (mode == 2'h2 && calm && input_pulse_event_o |-> sw_age <= 4'h3)
    else $error("input event without software write");
  ext_take_a: assert property (mode == 2'h1 && st == 2'h0 && calm && $rose(trig_line_i[sel])
    |-> ##[1:4] (input_pulse_event_o || trigger_lost_event_o)) else $error("line edge not taken");
  sync_take_a: assert property (mode == 2'h3 && st == 2'h0 && calm && !first_process_i
    && $rose(prev_trig_i) |-> ##[1:4] input_pulse_event_o) else $error("previous output not taken");
  first_none_a: assert property (mode == 2'h3 && calm && first_process_i && $past(first_process_i, 3)
    |-> !input_pulse_event_o) else $error("first process took a pulse");
  out_event_a: assert property ($rose(trig_out_o[0]) |-> output_pulse_event_o)
    else $error("output pulse without event");
  cover property (sw_wr ##[1:4] input_pulse_event_o);
  cover property (trigger_lost_event_o);
  cover property (st == 2'h2 && calm);
endmodule
bind tms_trigger_monitor tms_checker chk (.core_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .trig_line_i, .prev_trig_i, .first_process_i, .trig_out_o, .input_pulse_event_o,
  .output_pulse_event_o, .trigger_lost_event_o);

// ===== test/tms_far_side.sv
// Model of the trigger lines, the previous process and the camera around the monitor.
`timescale 1ns/1ps
module tms_far_side (
  // Clock and camera trigger.
  input wire clk_i,
  input wire cam_trig_i,
  // Sources and camera answer.
  output logic [3:0] line_o,
  output logic prev_o,
  output logic frame_done_o
);
  int cyc = 0;
  int rises[$];
  int answer_delay = 3;
  int wait_left = 0;
  bit answer_en = 1'b1;
  logic [3:0] line_q = 4'h0;
  logic cam_q = 1'b0;
  initial begin
    line_o = 4'h0;
    prev_o = 1'b0;
    frame_done_o = 1'b0;
  end
  // Lines stay high two cycles so no edge can slip between samples.
  task automatic pulse_line(input int idx);
    @(posedge clk_i);
    line_o <= 4'h1 << idx;
    repeat (2) @(posedge clk_i);
    line_o <= 4'h0;
  endtask
  task automatic pulse_prev();
    @(posedge clk_i);
    prev_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    prev_o <= 1'b0;
  endtask
  // The camera answers a trigger with one frame after a delay, unless told to stay silent; a new trigger during the delay restarts it.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    line_q <= line_o;
    cam_q <= cam_trig_i;
    frame_done_o <= (wait_left == 1);
    if ((line_o & ~line_q) != 4'h0) begin
      rises.push_back(cyc);
    end
    if (cam_trig_i && !cam_q && answer_en) begin
      wait_left <= answer_delay;
    end else if (wait_left > 0) begin
      wait_left <= wait_left - 1;
    end
  end
endmodule

// ===== test/tb.sv
// Self-checking bench for the trigger monitor with a counting model.
`timescale 1ns/1ps
module tb;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic first_process_i = 1'b0;
  logic pready_o, pslverr_o, prev_trig_i, frame_done_i, rd_e;
  logic input_pulse_event_o, output_pulse_event_o, trigger_lost_event_o, frame_lost_event_o;
  logic [31:0] prdata_o, rd_v, lo;
  logic [3:0] trig_line_i, trig_out_o;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int tin = 0, tout = 0, ein = 0, eout = 0, elost = 0;
  int sin = 0, sout = 0, slost = 0, sflost = 0;
  always #50 core_clk_i = ~core_clk_i;
  tms_trigger_monitor uut (.core_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pready_o, .prdata_o, .pslverr_o, .trig_line_i, .prev_trig_i, .first_process_i, .frame_done_i,
    .trig_out_o, .input_pulse_event_o, .output_pulse_event_o, .trigger_lost_event_o, .frame_lost_event_o);
  tms_far_side fs (.clk_i(core_clk_i), .cam_trig_i(trig_out_o[0]), .line_o(trig_line_i),
    .prev_o(prev_trig_i), .frame_done_o(frame_done_i));
  always @(posedge core_clk_i) begin
    cycles++;
    if (nrst_i) begin
      sin += input_pulse_event_o;
      sout += output_pulse_event_o;
      slost += trigger_lost_event_o;
      sflost += frame_lost_event_o;
    end
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
    end while (pready_o !== 1'b1);
    rd_v = prdata_o;
    rd_e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_v, exp);
  endtask
  task automatic gp(input int idx, input int gap);
    fs.pulse_line(idx);
    repeat (gap) @(posedge core_clk_i);
  endtask
  task automatic tallies();
    rd(8'h24, tin);
    rd(8'h28, tout);
    chk(sin, ein);
    chk(sout, eout);
    chk(slost, elost);
  endtask
  task automatic add(input int n, input int m);
    tin += n;
    ein += n;
    tout += m;
    eout += m;
  endtask
  initial begin
    int n, p, hi, i0;
    rd_v = $urandom(32'h785cdf2e);
    repeat (10) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rd(8'h00, 32'h4);
    rd(8'h04, 32'h0001312d);
    apb(1'b0, 8'hfc, 32'h0);
    chk({31'h0, rd_e}, 32'h1);
    chk(rd_v, 32'h0);
    apb(1'b1, 8'h04, 32'd40);
    apb(1'b1, 8'h00, 32'h41);
    gp(2, 80);
    add(1, 1);
    apb(1'b1, 8'h10, 32'h7);
    tin = 0;
    tout = 0;
    i0 = fs.rises.size();
    n = 4 + $urandom % 4;
    fs.answer_delay = 2 + $urandom % 28;
    for (int i = 0; i < n; i++) gp(2, 60 + $urandom % 30);
    add(n, n);
    lo = 32'hffffffff;
    hi = 0;
    for (int i = i0; i < fs.rises.size(); i++) begin
      p = fs.rises[i] - fs.rises[i - 1];
      if (p < lo) lo = p;
      if (p > hi) hi = p;
    end
    rd(8'h18, p);
    rd(8'h1c, lo);
    rd(8'h20, hi);
    tallies();
    gp(2, 0);
    gp(2, 100);
    add(2, 1);
    elost++;
    rd(8'h14, 32'h1);
    apb(1'b1, 8'h10, 32'h8);
    rd(8'h14, 32'h0);
    apb(1'b1, 8'h00, 32'h51);
    for (int i = 0; i < 3; i++) gp(2, 1);
    repeat (200) @(posedge core_clk_i);
    add(3, 3);
    tallies();
    apb(1'b1, 8'h10, 32'h6);
    tin = 0;
    tout = 0;
    tallies();
    apb(1'b1, 8'h00, 32'h2);
    n = 2 + $urandom % 3;
    for (int i = 0; i < n; i++) begin
      apb(1'b1, 8'h0c, $urandom);
      repeat (60) @(posedge core_clk_i);
    end
    gp(0, 60);
    add(n, n);
    tallies();
    apb(1'b1, 8'h00, 32'h3);
    fs.pulse_prev();
    repeat (60) @(posedge core_clk_i);
    first_process_i <= 1'b1;
    fs.pulse_prev();
    repeat (60) @(posedge core_clk_i);
    add(1, 1);
    tallies();
    apb(1'b1, 8'h00, 32'h5);
    gp(0, 60);
    tallies();
    fs.answer_delay = 3;
    apb(1'b1, 8'h00, 32'h1);
    gp(0, 6);
    apb(1'b1, 8'h00, 32'h9);
    repeat (10) @(posedge core_clk_i);
    apb(1'b1, 8'h00, 32'h1);
    gp(0, 100);
    add(2, 2);
    tallies();
    fs.answer_en = 1'b0;
    apb(1'b1, 8'h10, 32'h10);
    for (int i = 0; i < 3; i++) gp(0, 60);
    add(3, 3);
    rd(8'h2c, 32'h2);
    chk(sflost, 32'h2);
    tallies();
    apb(1'b1, 8'h00, 32'h0);
    gp(0, 412);
    apb(1'b1, 8'h00, 32'h4);
    repeat (60) @(posedge core_clk_i);
    add(10, 10);
    tallies();
    end_sim();
  end
endmodule
